// [src/icmf_framer.sv]
// image metadata framer: register slave, per-frame latching, trailer builder and output fifo
//
// Notes on behaviour
// - trailer records are appended only while the master enable is set
// - image and check-value records enabled at reset and cannot be cleared
// - one include flag per item, reached through the item selector
// - master enable and include flags are refused while acquisition runs
// - selector covers image, crc, frame, region, exposure, gain, black, format and more
// - check-value record carries crc-32 over this frame's image words
// - frame number record reports the id of the accompanying frame
// - region records report offsets, width and height of this image
// - exposure record reports microseconds actually used for this image
// - gain record returns the channel chosen by the gain selector
// - black level selector has only the all-channels choice
// - timestamp record reports capture time of this image
// - sequencer record reports the set active for this frame
// - line levels are captured at end of exposure as one bit vector
// - serial record carries received bytes and how many were included
// - read-only flag reports that serial bytes overflowed the record
// - pixel format record identifies one of ten formats
// - value records are read-only; only enable, item, gain and black selectors and flags are writable
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "icmf_defines.svh"

// ----------------------------------------------------------------
// output fifo
// ----------------------------------------------------------------
module icmf_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // fill side
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  // drain side
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = wr_valid & wr_ready;
  wire pop = rd_valid & rd_ready;
  assign wr_ready = count != (AW+1)'(DEPTH);
  assign rd_valid = count != '0;
  assign rd_data = mem[rd_ptr];
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= wr_data;
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= push ? wr_ptr + AW'(1) : wr_ptr;
      rd_ptr <= pop ? rd_ptr + AW'(1) : rd_ptr;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ----------------------------------------------------------------
// framer top
// ----------------------------------------------------------------
module icmf_framer (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // axi4-lite write
  input wire logic [`ICMF_ADDR_W-1:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  // axi4-lite read
  input wire logic [`ICMF_ADDR_W-1:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  // acquisition state and capture values
  input wire logic acquisition_active,
  input wire logic exposure_end,
  input wire icmf_pkg::icmf_meta_t capture_meta,
  input wire logic [7:0] line_levels_pin,
  // serial receive bytes
  input wire logic serial_rx_valid,
  input wire logic [7:0] serial_rx_byte,
  // image words in
  input wire logic pix_valid,
  output logic pix_ready,
  input wire logic [31:0] pix_data,
  input wire logic pix_last,
  // framed payload out
  output logic out_valid,
  input wire logic out_ready,
  output logic [31:0] out_data,
  output logic out_last
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic master_enable;
  logic [3:0] item_select;
  logic [`ICMF_ITEM_COUNT-1:0] item_include;
  icmf_pkg::icmf_gain_sel_t gain_channel_select;
  icmf_pkg::icmf_meta_t cap_meta;
  icmf_pkg::icmf_meta_t frm_meta;
  logic [7:0] line_sync1;
  logic [7:0] line_sync2;
  logic [7:0] cap_lines;
  logic [7:0] exposure_end_line_levels;
  logic [`ICMF_ITEM_COUNT-1:0] frm_include;
  logic frm_active;
  logic [31:0] crc;
  logic [31:0] payload_check_value;
  logic [31:0] ser_buf [`ICMF_SERIAL_WORDS];
  logic [31:0] serial_bytes_record [`ICMF_SERIAL_WORDS];
  logic [4:0] ser_cnt;
  logic ser_ovf;
  logic [4:0] serial_bytes_count;
  logic serial_capture_overflow;
  icmf_pkg::icmf_state_t state;
  icmf_pkg::icmf_state_t next_state;
  logic [3:0] item_idx;
  logic [2:0] word_idx;

  // ----------------------------------------------------------------
  // crc-32 over one image word, msb first
  // ----------------------------------------------------------------
  function automatic logic [31:0] crc_word(input logic [31:0] c, input logic [31:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 31; i >= 0; i--) begin
      r = (r[31] ^ d[i]) ? ((r << 1) ^ `ICMF_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  logic aw_full;
  logic w_full;
  logic [`ICMF_ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic w_lane0;
  logic [31:0] rd_word;
  logic rd_hit;
  assign s_axil_awready = !aw_full && !s_axil_bvalid;
  assign s_axil_wready = !w_full && !s_axil_bvalid;
  assign s_axil_arready = !s_axil_rvalid;
  wire wr_fire = aw_full && w_full;
  wire ar_take = s_axil_arvalid && s_axil_arready;
  // enable and include flags are frozen while the sensor runs so every frame in a run matches
  wire is_ctrl = aw_addr == `ICMF_REG_CTRL;
  wire is_sel = aw_addr == `ICMF_REG_ITEM_SEL;
  wire is_incl = aw_addr == `ICMF_REG_ITEM_INCL;
  wire is_gain = aw_addr == `ICMF_REG_GAIN_SEL;
  wire is_black = aw_addr == `ICMF_REG_BLACK_SEL;
  wire locked = acquisition_active && (is_ctrl || is_incl);
  wire bad_sel = is_sel && (w_data[3:0] > `ICMF_ITEM_SEL_MAX || w_data[31:4] != '0);
  wire bad_black = is_black && w_data != '0;
  // value records have no write path at all
  wire wr_mapped = is_ctrl || is_sel || is_incl || is_gain || is_black;
  wire wr_err = !wr_mapped || locked || bad_sel || bad_black;
  wire wr_do = wr_fire && !wr_err && w_lane0;
  logic [`ICMF_ITEM_COUNT-1:0] next_include;
  always_comb begin
    next_include = item_include;
    next_include[item_select] = w_data[0];
    next_include = next_include | `ICMF_INCL_RESET;
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_lane0 <= 1'b0;
      s_axil_bvalid <= 1'b0;
      s_axil_bresp <= `ICMF_RESP_OKAY;
    end else begin
      if (s_axil_awvalid && s_axil_awready) begin
        aw_full <= 1'b1;
        aw_addr <= s_axil_awaddr;
      end else if (wr_fire) begin
        aw_full <= 1'b0;
      end
      if (s_axil_wvalid && s_axil_wready) begin
        w_full <= 1'b1;
        w_data <= s_axil_wdata;
        w_lane0 <= s_axil_wstrb[0];
      end else if (wr_fire) begin
        w_full <= 1'b0;
      end
      if (wr_fire) begin
        s_axil_bvalid <= 1'b1;
        s_axil_bresp <= wr_err ? `ICMF_RESP_SLVERR : `ICMF_RESP_OKAY;
      end else if (s_axil_bready) begin
        s_axil_bvalid <= 1'b0;
      end
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      master_enable <= 1'b0;
      item_select <= 4'h0;
      item_include <= `ICMF_INCL_RESET;
      gain_channel_select <= icmf_pkg::GAIN_ALL;
    end else if (wr_do) begin
      if (is_ctrl) begin
        master_enable <= w_data[0];
      end
      if (is_sel) begin
        item_select <= w_data[3:0];
      end
      if (is_incl) begin
        item_include <= next_include;
      end
      if (is_gain) begin
        gain_channel_select <= icmf_pkg::icmf_gain_sel_t'(w_data[1:0]);
      end
    end
  end

  // ----------------------------------------------------------------
  // register read view
  // ----------------------------------------------------------------
  logic [15:0] gain_record;
  always_comb begin
    unique case (gain_channel_select)
      icmf_pkg::GAIN_ALL: gain_record = frm_meta.gain_all;
      icmf_pkg::GAIN_RED: gain_record = frm_meta.gain_red;
      icmf_pkg::GAIN_GREEN: gain_record = frm_meta.gain_green;
      icmf_pkg::GAIN_BLUE: gain_record = frm_meta.gain_blue;
    endcase
  end
  wire [5:0] rd_ser_idx = s_axil_araddr[7:2] - 6'(`ICMF_REG_SER_DATA0 >> 2);
  wire rd_is_ser = s_axil_araddr[1:0] == 2'h0 && rd_ser_idx < 6'(`ICMF_SERIAL_WORDS);
  always_comb begin
    rd_hit = 1'b1;
    rd_word = 32'h0;
    unique case (s_axil_araddr)
      `ICMF_REG_CTRL: rd_word = {30'h0, acquisition_active, master_enable};
      `ICMF_REG_ITEM_SEL: rd_word = {28'h0, item_select};
      `ICMF_REG_ITEM_INCL: rd_word = {31'h0, item_include[item_select]};
      `ICMF_REG_GAIN_SEL: rd_word = {30'h0, gain_channel_select};
      `ICMF_REG_BLACK_SEL: rd_word = 32'h0;
      `ICMF_REG_STATUS: rd_word = {31'h0, serial_capture_overflow};
      `ICMF_REG_CRC: rd_word = payload_check_value;
      `ICMF_REG_FRAME: rd_word = frm_meta.frame_number;
      `ICMF_REG_OFFX: rd_word = {16'h0, frm_meta.offset_x};
      `ICMF_REG_OFFY: rd_word = {16'h0, frm_meta.offset_y};
      `ICMF_REG_WIDTH: rd_word = {16'h0, frm_meta.width};
      `ICMF_REG_HEIGHT: rd_word = {16'h0, frm_meta.height};
      `ICMF_REG_EXPOSURE: rd_word = frm_meta.exposure_us;
      `ICMF_REG_GAIN: rd_word = {16'h0, gain_record};
      `ICMF_REG_BLACK: rd_word = {16'h0, frm_meta.black_level};
      `ICMF_REG_PIXFMT: rd_word = {28'h0, frm_meta.pixel_format};
      `ICMF_REG_TIME_LO: rd_word = frm_meta.capture_time[31:0];
      `ICMF_REG_TIME_HI: rd_word = frm_meta.capture_time[63:32];
      `ICMF_REG_SEQ: rd_word = {24'h0, frm_meta.sequence_step};
      `ICMF_REG_LINES: rd_word = {24'h0, exposure_end_line_levels};
      `ICMF_REG_SER_COUNT: rd_word = {27'h0, serial_bytes_count};
      default: begin
        rd_hit = rd_is_ser;
        rd_word = rd_is_ser ? serial_bytes_record[rd_ser_idx[1:0]] : 32'h0;
      end
    endcase
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axil_rvalid <= 1'b0;
      s_axil_rdata <= 32'h0;
      s_axil_rresp <= `ICMF_RESP_OKAY;
    end else if (ar_take) begin
      s_axil_rvalid <= 1'b1;
      s_axil_rdata <= rd_word;
      s_axil_rresp <= rd_hit ? `ICMF_RESP_OKAY : `ICMF_RESP_SLVERR;
    end else if (s_axil_rready) begin
      s_axil_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // capture at end of exposure, latch per frame
  // ----------------------------------------------------------------
  wire fifo_ready;
  wire in_image = state == icmf_pkg::ST_IDLE || state == icmf_pkg::ST_IMAGE;
  assign pix_ready = fifo_ready && in_image;
  wire pix_take = pix_valid && pix_ready;
  wire frame_start = pix_take && state == icmf_pkg::ST_IDLE;
  wire pix_end = pix_take && pix_last;
  wire go_trail = (state == icmf_pkg::ST_IDLE) ? master_enable : frm_active;
  wire [31:0] crc_base = (state == icmf_pkg::ST_IDLE) ? `ICMF_CRC_INIT : crc;
  wire [31:0] crc_next = crc_word(crc_base, pix_data);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      line_sync1 <= 8'h0;
      line_sync2 <= 8'h0;
      cap_lines <= 8'h0;
      cap_meta <= '0;
    end else begin
      line_sync1 <= line_levels_pin;
      line_sync2 <= line_sync1;
      if (exposure_end) begin
        cap_lines <= line_sync2;
        cap_meta <= capture_meta;
      end
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      frm_meta <= '0;
      exposure_end_line_levels <= 8'h0;
      frm_include <= `ICMF_INCL_RESET;
      frm_active <= 1'b0;
      crc <= `ICMF_CRC_INIT;
      payload_check_value <= 32'h0;
    end else begin
      if (frame_start) begin
        frm_meta <= cap_meta;
        exposure_end_line_levels <= cap_lines;
        frm_include <= item_include | `ICMF_INCL_RESET;
        frm_active <= master_enable;
      end
      if (pix_take) begin
        crc <= crc_next;
      end
      if (pix_end) begin
        payload_check_value <= ~crc_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // serial byte collection, handed to the frame at its start
  // ----------------------------------------------------------------
  // bytes past the record's capacity are dropped, only the flag remains
  wire ser_room = ser_cnt != `ICMF_SERIAL_BYTES;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ser_cnt <= 5'h0;
      ser_ovf <= 1'b0;
      serial_bytes_count <= 5'h0;
      serial_capture_overflow <= 1'b0;
      for (int i = 0; i < `ICMF_SERIAL_WORDS; i++) begin
        ser_buf[i] <= 32'h0;
        serial_bytes_record[i] <= 32'h0;
      end
    end else if (frame_start) begin
      // a byte arriving in the hand-over cycle opens the next record
      serial_bytes_record <= ser_buf;
      serial_bytes_count <= ser_cnt;
      serial_capture_overflow <= ser_ovf;
      ser_cnt <= {4'h0, serial_rx_valid};
      ser_ovf <= 1'b0;
      for (int i = 0; i < `ICMF_SERIAL_WORDS; i++) begin
        ser_buf[i] <= 32'h0;
      end
      ser_buf[0][7:0] <= serial_rx_valid ? serial_rx_byte : 8'h0;
    end else if (serial_rx_valid) begin
      if (ser_room) begin
        ser_buf[ser_cnt[3:2]][ser_cnt[1:0]*8 +: 8] <= serial_rx_byte;
        ser_cnt <= ser_cnt + 5'h1;
      end else begin
        ser_ovf <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // trailer builder: header word then value words per included item
  // ----------------------------------------------------------------
  wire item_on = frm_include[item_idx];
  wire [`ICMF_ITEM_COUNT-1:0] above = frm_include >> item_idx;
  wire higher = |above[`ICMF_ITEM_COUNT-1:1];
  logic [2:0] item_len;
  logic [31:0] trail_word;
  always_comb begin
    unique case (item_idx)
      icmf_pkg::ITEM_TIME: item_len = 3'h2;
      icmf_pkg::ITEM_SERIAL: item_len = 3'h5;
      default: item_len = 3'h1;
    endcase
  end
  wire last_word = word_idx == item_len;
  wire trail_last = last_word && !higher;
  always_comb begin
    trail_word = {20'h0, item_idx, 5'h0, item_len};
    if (word_idx != 3'h0) begin
      unique case (item_idx)
        icmf_pkg::ITEM_CRC: trail_word = payload_check_value;
        icmf_pkg::ITEM_FRAME: trail_word = frm_meta.frame_number;
        icmf_pkg::ITEM_OFFX: trail_word = {16'h0, frm_meta.offset_x};
        icmf_pkg::ITEM_OFFY: trail_word = {16'h0, frm_meta.offset_y};
        icmf_pkg::ITEM_WIDTH: trail_word = {16'h0, frm_meta.width};
        icmf_pkg::ITEM_HEIGHT: trail_word = {16'h0, frm_meta.height};
        icmf_pkg::ITEM_EXPOSURE: trail_word = frm_meta.exposure_us;
        icmf_pkg::ITEM_GAIN: trail_word = {16'h0, gain_record};
        icmf_pkg::ITEM_BLACK: trail_word = {16'h0, frm_meta.black_level};
        icmf_pkg::ITEM_PIXFMT: trail_word = {28'h0, frm_meta.pixel_format};
        icmf_pkg::ITEM_TIME: begin
          trail_word = (word_idx == 3'h1) ? frm_meta.capture_time[31:0]
                                          : frm_meta.capture_time[63:32];
        end
        icmf_pkg::ITEM_SEQ: trail_word = {24'h0, frm_meta.sequence_step};
        icmf_pkg::ITEM_SERIAL: begin
          trail_word = (word_idx == 3'h1) ? {27'h0, serial_bytes_count}
                       : serial_bytes_record[2'(word_idx - 3'h2)];
        end
        icmf_pkg::ITEM_LINES: trail_word = {24'h0, exposure_end_line_levels};
        default: trail_word = 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------
  wire in_trail = state == icmf_pkg::ST_TRAIL;
  wire trail_wr = in_trail && item_on;
  wire trail_take = trail_wr && fifo_ready;
  wire fifo_wr_valid = (pix_valid && in_image) || trail_wr;
  icmf_pkg::icmf_word_t fifo_in;
  icmf_pkg::icmf_word_t fifo_out;
  assign fifo_in = in_trail ? {trail_last, trail_word} : {pix_last && !go_trail, pix_data};
  always_comb begin
    next_state = state;
    unique case (state)
      icmf_pkg::ST_IDLE, icmf_pkg::ST_IMAGE: begin
        if (pix_end) begin
          next_state = go_trail ? icmf_pkg::ST_TRAIL : icmf_pkg::ST_IDLE;
        end else if (pix_take) begin
          next_state = icmf_pkg::ST_IMAGE;
        end
      end
      icmf_pkg::ST_TRAIL: begin
        if (trail_take && trail_last) begin
          next_state = icmf_pkg::ST_IDLE;
        end
      end
      default: next_state = icmf_pkg::ST_IDLE;
    endcase
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= icmf_pkg::ST_IDLE;
      item_idx <= icmf_pkg::ITEM_CRC;
      word_idx <= 3'h0;
    end else begin
      state <= next_state;
      if (!in_trail) begin
        item_idx <= icmf_pkg::ITEM_CRC;
        word_idx <= 3'h0;
      end else if (!item_on || (trail_take && last_word)) begin
        item_idx <= item_idx + 4'h1;
        word_idx <= 3'h0;
      end else if (trail_take) begin
        word_idx <= word_idx + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // output buffer
  // ----------------------------------------------------------------
  icmf_fifo #(
    .WIDTH($bits(icmf_pkg::icmf_word_t)),
    .DEPTH(`ICMF_FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr_valid(fifo_wr_valid),
    .wr_ready(fifo_ready),
    .wr_data(fifo_in),
    .rd_valid(out_valid),
    .rd_ready(out_ready),
    .rd_data(fifo_out)
  );
  assign out_data = fifo_out.data;
  assign out_last = fifo_out.last;
endmodule

// [src/icmf_defines.svh]
// register map, reset values and sizes of the image metadata framer
`ifndef ICMF_DEFINES_SVH
`define ICMF_DEFINES_SVH
`define ICMF_ADDR_W 8
`define ICMF_REG_CTRL 8'h00
`define ICMF_REG_ITEM_SEL 8'h04
`define ICMF_REG_ITEM_INCL 8'h08
`define ICMF_REG_GAIN_SEL 8'h0c
`define ICMF_REG_BLACK_SEL 8'h10
`define ICMF_REG_STATUS 8'h14
`define ICMF_REG_CRC 8'h20
`define ICMF_REG_FRAME 8'h24
`define ICMF_REG_OFFX 8'h28
`define ICMF_REG_OFFY 8'h2c
`define ICMF_REG_WIDTH 8'h30
`define ICMF_REG_HEIGHT 8'h34
`define ICMF_REG_EXPOSURE 8'h38
`define ICMF_REG_GAIN 8'h3c
`define ICMF_REG_BLACK 8'h40
`define ICMF_REG_PIXFMT 8'h44
`define ICMF_REG_TIME_LO 8'h48
`define ICMF_REG_TIME_HI 8'h4c
`define ICMF_REG_SEQ 8'h50
`define ICMF_REG_LINES 8'h54
`define ICMF_REG_SER_COUNT 8'h58
`define ICMF_REG_SER_DATA0 8'h60
`define ICMF_ITEM_COUNT 15
`define ICMF_INCL_RESET 15'h0003
`define ICMF_ITEM_SEL_MAX 4'he
`define ICMF_SERIAL_WORDS 4
`define ICMF_SERIAL_BYTES 5'h10
`define ICMF_FIFO_DEPTH 8
`define ICMF_CRC_POLY 32'h04c11db7
`define ICMF_CRC_INIT 32'hffffffff
`define ICMF_RESP_OKAY 2'h0
`define ICMF_RESP_SLVERR 2'h2
`endif

// [src/icmf_pkg.sv]
// types shared by the image metadata framer
package icmf_pkg;
  typedef enum logic [3:0] {
    ITEM_IMAGE = 4'h0, ITEM_CRC = 4'h1, ITEM_FRAME = 4'h2, ITEM_OFFX = 4'h3,
    ITEM_OFFY = 4'h4, ITEM_WIDTH = 4'h5, ITEM_HEIGHT = 4'h6, ITEM_EXPOSURE = 4'h7,
    ITEM_GAIN = 4'h8, ITEM_BLACK = 4'h9, ITEM_PIXFMT = 4'ha, ITEM_TIME = 4'hb,
    ITEM_SEQ = 4'hc, ITEM_SERIAL = 4'hd, ITEM_LINES = 4'he
  } icmf_item_t;
  typedef enum logic [3:0] {
    PIX_MONO8 = 4'h0, PIX_MONO12_PACKED = 4'h1, PIX_MONO16 = 4'h2, PIX_RGB8_PACKED = 4'h3,
    PIX_YUV422_PACKED = 4'h4, PIX_BAYER_GR8 = 4'h5, PIX_BAYER_RG8 = 4'h6,
    PIX_BAYER_GB8 = 4'h7, PIX_BAYER_BG8 = 4'h8, PIX_CBYCRY_422_8 = 4'h9
  } icmf_pixfmt_t;
  typedef enum logic [1:0] {
    GAIN_ALL = 2'h0, GAIN_RED = 2'h1, GAIN_GREEN = 2'h2, GAIN_BLUE = 2'h3
  } icmf_gain_sel_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_IMAGE = 2'b01, ST_TRAIL = 2'b10
  } icmf_state_t;
  typedef struct packed {
    logic [31:0] frame_number;
    logic [15:0] offset_x;
    logic [15:0] offset_y;
    logic [15:0] width;
    logic [15:0] height;
    logic [31:0] exposure_us;
    logic [15:0] gain_all;
    logic [15:0] gain_red;
    logic [15:0] gain_green;
    logic [15:0] gain_blue;
    logic [15:0] black_level;
    icmf_pixfmt_t pixel_format;
    logic [63:0] capture_time;
    logic [7:0] sequence_step;
  } icmf_meta_t;
  typedef struct packed {
    logic last;
    logic [31:0] data;
  } icmf_word_t;
endpackage

// [tb/icmf_chk.sv]
// port assertions for the image metadata framer
`timescale 1ns/1ps
module icmf_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register bus
  input wire logic s_axil_awready,
  input wire logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic s_axil_arready,
  input wire logic s_axil_rvalid,
  input wire logic s_axil_rready,
  // streams
  input wire logic pix_valid,
  input wire logic pix_ready,
  input wire logic out_valid,
  input wire logic out_ready
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_out_wait; out_valid && !out_ready; endsequence
  a_b_holds: assert property (s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid)
    else $error("bvalid dropped");
  a_aw_blocked: assert property (s_axil_bvalid |-> !s_axil_awready)
    else $error("awready with bvalid");
  a_r_holds: assert property (s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid)
    else $error("rvalid dropped");
  a_r_release: assert property (s_axil_rvalid && s_axil_rready |=> !s_axil_rvalid)
    else $error("rvalid stuck");
  a_ar_blocked: assert property (s_axil_rvalid |-> !s_axil_arready)
    else $error("arready with rvalid");
  a_pix_out: assert property (pix_valid && pix_ready |=> out_valid)
    else $error("image word lost");
  a_out_holds: assert property (s_out_wait |=> out_valid)
    else $error("out_valid dropped");
  a_reset_quiet: assert property ($rose(rst_n) |-> !s_axil_bvalid && !out_valid)
    else $error("busy after reset");
endmodule
bind icmf_framer icmf_chk u_icmf_chk (.*);

// [tb/icmf_host.sv]
// host model draining the framed payload
`timescale 1ns/1ps
module icmf_host (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // payload in; slow stalls every other cycle
  input wire logic slow,
  input wire logic out_valid,
  input wire logic [31:0] out_data,
  input wire logic out_last,
  output logic out_ready
);
  logic [32:0] got[$];
  always @(posedge mclk or negedge rst_n) begin
    out_ready <= rst_n && (!slow || !out_ready);
    if (rst_n && out_valid && out_ready) got.push_back({out_last, out_data});
  end
endmodule

// [tb/icmf_framer_tb_top.sv]
// bench for the image metadata framer
`timescale 1ns/1ps
`include "icmf_defines.svh"
module icmf_framer_tb_top;
  logic mclk = 1'h0, rst_n = 1'h0, slow = 1'h0, exposure_end = 1'h0, pix_valid = 1'h0;
  logic s_axil_awvalid = 1'h0, s_axil_wvalid = 1'h0, s_axil_bready = 1'h0;
  logic s_axil_arvalid = 1'h0, s_axil_rready = 1'h0, acquisition_active = 1'h0;
  logic serial_rx_valid = 1'h0, pix_last = 1'h1;
  logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
  logic pix_ready, out_valid, out_ready, out_last;
  logic [1:0] s_axil_bresp, s_axil_rresp;
  logic [3:0] s_axil_wstrb = 4'hf;
  logic [7:0] s_axil_awaddr = 8'h0, s_axil_araddr = 8'h0, line_levels_pin = 8'h0;
  logic [7:0] serial_rx_byte = 8'h0;
  logic [31:0] s_axil_wdata = 32'h0, pix_data = 32'h0, s_axil_rdata, out_data;
  icmf_pkg::icmf_meta_t capture_meta = '0;
  int n_mismatch = 0, checks = 0;
  always #4 mclk = ~mclk;
  icmf_framer u_icmf_framer (.*);
  icmf_host u_icmf_host (.*);
  task automatic chk(string what, logic [33:0] exp, logic [33:0] got);
    checks++;
    if (exp !== got) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // reference crc: word msb first, non-reflected, inverted at the end
  function automatic logic [31:0] crc_ref(logic [31:0] d);
    logic [31:0] r = `ICMF_CRC_INIT;
    for (int i = 31; i >= 0; i--) begin
      r = {r[30:0], 1'h0} ^ ((r[31] ^ d[i]) ? `ICMF_CRC_POLY : 32'h0);
    end
    return ~r;
  endfunction
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic tmo(logic ok);
    if (!ok) begin
      chk("handshake", 1, 0);
      summarize();
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] e);
    logic ta, tw, tb = 1'h0;
    logic [1:0] r;
    @(posedge mclk);
    {s_axil_awaddr, s_axil_wdata} <= {a, d};
    {s_axil_awvalid, s_axil_wvalid, s_axil_bready} <= 3'h7;
    for (int n = 0; n < 99 && !tb; n++) begin
      @(negedge mclk);
      {ta, tw, tb, r} = {s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_bresp};
      @(posedge mclk);
      s_axil_awvalid <= s_axil_awvalid & ~ta;
      s_axil_wvalid <= s_axil_wvalid & ~tw;
    end
    s_axil_bready <= 1'h0;
    tmo(tb);
    chk("bresp", e, r);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e, logic [1:0] er);
    logic ta, tv = 1'h0;
    logic [33:0] g;
    @(posedge mclk);
    s_axil_araddr <= a;
    {s_axil_arvalid, s_axil_rready} <= 2'h3;
    for (int n = 0; n < 99 && !tv; n++) begin
      @(negedge mclk);
      {ta, tv, g} = {s_axil_arready, s_axil_rvalid, s_axil_rresp, s_axil_rdata};
      @(posedge mclk);
      s_axil_arvalid <= s_axil_arvalid & ~ta;
    end
    s_axil_rready <= 1'h0;
    tmo(tv);
    chk("rdata", {er, e}, g);
  endtask
  task automatic frame(logic [31:0] w, int len, logic [31:0] fr);
    logic tp = 1'h0;
    u_icmf_host.got.delete();
    @(posedge mclk);
    {exposure_end, capture_meta.frame_number} <= {1'h1, fr};
    @(posedge mclk);
    {exposure_end, pix_valid, pix_data} <= {2'h1, w};
    for (int n = 0; n < 99 && !tp; n++) begin
      @(negedge mclk);
      tp = pix_ready;
      @(posedge mclk);
    end
    pix_valid <= 1'h0;
    tmo(tp);
    for (int n = 0; n < 99 && u_icmf_host.got.size() < len; n++) @(posedge mclk);
    chk("words", len, u_icmf_host.got.size());
    chk("image", w, u_icmf_host.got[0][31:0]);
    chk("last", 1, u_icmf_host.got[len-1][32]);
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'h1;
    rd(8'h00, 32'h0, 2'h0);
    rd(8'h08, 32'h1, 2'h0);
    rd(8'hfc, 32'h0, 2'h2);
    wr(8'h04, 32'h1, 2'h0);
    wr(8'h08, 32'h0, 2'h0);
    rd(8'h08, 32'h1, 2'h0);
    wr(8'h04, 32'hf, 2'h2);
    wr(8'h04, 32'h2, 2'h0);
    wr(8'h08, 32'h1, 2'h0);
    wr(8'h24, 32'h7, 2'h2);
    frame(32'hcafe0001, 1, 32'h4);
    wr(8'h00, 32'h1, 2'h0);
    acquisition_active <= 1'h1;
    wr(8'h00, 32'h0, 2'h2);
    wr(8'h08, 32'h0, 2'h2);
    // one serial byte and fresh line levels, settled before the exposure end
    {slow, serial_rx_valid, serial_rx_byte, line_levels_pin} <= {2'h3, 16'h3ca5};
    @(posedge mclk) serial_rx_valid <= 1'h0;
    frame(32'hcafe0002, 5, 32'h5);
    chk("crc header", 34'h101, u_icmf_host.got[1]);
    chk("crc record", {2'h0, crc_ref(32'hcafe0002)}, u_icmf_host.got[2]);
    chk("frame header", 34'h201, u_icmf_host.got[3]);
    chk("frame record", 34'h100000005, u_icmf_host.got[4]);
    rd(8'h24, 32'h5, 2'h0);
    rd(8'h20, crc_ref(32'hcafe0002), 2'h0);
    rd(8'h54, 32'ha5, 2'h0);
    rd(8'h58, 32'h1, 2'h0);
    rd(8'h60, 32'h3c, 2'h0);
    rd(8'h14, 32'h0, 2'h0);
    rd(8'h00, 32'h3, 2'h0);
    summarize();
  end
endmodule
